// ==== src/cpu_seq_pkg.sv ====
// Shared constants and types for the instruction sequencer and exception front end
// Operation
// - Three-stage instruction FIFO, stages A, B, C
// - Opcodes latch into A, advance to B
// - Operands from stage B are eight bits
// - Finished opcode moves B to C
// - Counter is six bytes ahead at start
// - Two multiplexed tracking outputs from sequencing
// - Flow change loads new stream address
// - Flush A and B, keep return address
// - Bus cycle at least two whole clocks
// - Internal operations take two clocks each
// - One instruction executes at a time
// - Vector table in lowest 512 bytes, bank 0
// - Reset four program words, others one data word
// - 56 fixed vectors, user vectors 38 to FF
// - Vector address is number shifted left once
// - Vectors come from outside or core
// - Reset words give banks, counter, stack, index
// - Fixed vector numbers for core exceptions
// - Stack counter and condition codes at stack
// - Stacked counter is next instruction plus six
// - Clear program bank, then load vector
// - Eight active-low states over two phases
package cpu_seq_pkg;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned VEC_W = 8;
  localparam int unsigned VTAB_AW = 9;  // 512-byte table
  localparam logic [1:0] RST_WORDS_LAST = 2'h3;
  localparam int unsigned PBANK_LSB = 0;
  localparam int unsigned SBANK_LSB = 4;
  localparam int unsigned ZBANK_LSB = 8;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] PF_AHEAD = 16'h0006;
  localparam logic [19:0] RET_OFS = 20'h00006;
  localparam logic [7:0] VEC_BKPT = 8'h04;
  localparam logic [7:0] VEC_BUSERR = 8'h05;
  localparam logic [7:0] VEC_SWI = 8'h06;
  localparam logic [7:0] VEC_ILLEGAL = 8'h07;
  localparam logic [7:0] VEC_DIVZERO = 8'h08;
  localparam logic [7:0] VEC_UNINIT = 8'h0f;
  localparam logic [7:0] VEC_AUTO_BASE = 8'h10;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_USER_FIRST = 8'h38;
  typedef enum logic [2:0] {
    EXK_BKPT     = 3'h0,
    EXK_BUSERR   = 3'h1,
    EXK_SWI      = 3'h2,
    EXK_ILLEGAL  = 3'h3,
    EXK_DIVZERO  = 3'h4,
    EXK_UNINIT   = 3'h5,
    EXK_SPURIOUS = 3'h6
  } exc_kind_t;
endpackage

// ==== src/core_link_if.sv ====
// Links the sequencer to its tracking encoder and vector mapper
`timescale 1ns/1ps
interface core_link_if;
  logic                  fetch;
  logic                  start;
  logic                  advance;
  logic                  excp;
  logic                  invalid;
  logic                  xext;
  logic                  xauto;
  logic [2:0]            xlvl;
  logic [7:0]            xvec;
  cpu_seq_pkg::exc_kind_t xkind;
  logic [7:0]            vnum;
  logic [8:0]            vaddr;
  logic                  vuser;
  modport seq (output fetch, start, advance, excp, invalid, xext, xauto, xlvl, xvec, xkind,
               input vnum, vaddr, vuser);
  modport enc (input fetch, start, advance, excp, invalid);
  modport map (input xext, xauto, xlvl, xvec, xkind, output vnum, vaddr, vuser);
endinterface

// ==== src/vec_map.sv ====
// Maps an exception source to its vector number and table address
`timescale 1ns/1ps
module vec_map (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Exception source and vector
  core_link_if.map  lk
);
  typedef struct packed {
    logic [7:0] num;
    logic [8:0] addr;
    logic       user;
  } map_t;
  map_t s, n;

  // Pick the vector number, then shift it into a table offset
  always_comb begin
    n = s;
    if (lk.xext && lk.xauto) begin
      n.num = 8'(cpu_seq_pkg::VEC_AUTO_BASE + {5'h00, lk.xlvl});
    end else if (lk.xext) begin
      n.num = lk.xvec;
    end else begin
      unique case (lk.xkind)
        cpu_seq_pkg::EXK_BKPT:     n.num = cpu_seq_pkg::VEC_BKPT;
        cpu_seq_pkg::EXK_BUSERR:   n.num = cpu_seq_pkg::VEC_BUSERR;
        cpu_seq_pkg::EXK_SWI:      n.num = cpu_seq_pkg::VEC_SWI;
        cpu_seq_pkg::EXK_ILLEGAL:  n.num = cpu_seq_pkg::VEC_ILLEGAL;
        cpu_seq_pkg::EXK_DIVZERO:  n.num = cpu_seq_pkg::VEC_DIVZERO;
        cpu_seq_pkg::EXK_UNINIT:   n.num = cpu_seq_pkg::VEC_UNINIT;
        cpu_seq_pkg::EXK_SPURIOUS: n.num = cpu_seq_pkg::VEC_SPURIOUS;
        default:                   n.num = cpu_seq_pkg::VEC_SPURIOUS;
      endcase
    end
    n.addr = {n.num, 1'b0};
    n.user = (n.num >= cpu_seq_pkg::VEC_USER_FIRST);
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign lk.vnum  = s.num;
  assign lk.vaddr = s.addr;
  assign lk.vuser = s.user;

  property p_autovec;
    @(posedge core_clk) disable iff (!rstn)
    (lk.xext && lk.xauto) |=> (lk.vnum == 8'(cpu_seq_pkg::VEC_AUTO_BASE + $past(lk.xlvl)));
  endproperty
  a_autovec: assert property (p_autovec) else $error("autovector number wrong");
endmodule

// ==== src/track_enc.sv ====
// Multiplexes pipeline events onto two active-low tracking lines
`timescale 1ns/1ps
module track_enc (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Pipeline events
  core_link_if.enc  lk,
  // Tracking lines
  output logic      trk_a,
  output logic      trk_b,
  output logic      trk_phase
);
  typedef struct packed {
    logic ph;
    logic p_fetch;
    logic p_start;
    logic p_adv;
    logic p_exc;
    logic p_inv;
    logic a;
    logic b;
  } enc_t;
  enc_t s, n;

  // Phase one shows start/fetch, phase two shows invalid/advance/exception
  always_comb begin
    n = s;
    n.p_fetch = s.p_fetch | lk.fetch;
    n.p_start = s.p_start | lk.start;
    n.p_adv   = s.p_adv | lk.advance;
    n.p_exc   = s.p_exc | lk.excp;
    n.p_inv   = s.p_inv | lk.invalid;
    n.ph      = ~s.ph;
    if (!s.ph) begin
      n.b = ~n.p_fetch;
      n.a = ~n.p_start;
      n.p_fetch = 1'b0;
      n.p_start = 1'b0;
    end else if (n.p_inv) begin
      n.b = 1'b0;
      n.a = 1'b0;
      n.p_inv = 1'b0;
    end else if (n.p_adv) begin
      n.b = 1'b0;
      n.a = 1'b1;
      n.p_adv = 1'b0;
    end else begin
      n.b = 1'b1;
      n.a = ~n.p_exc;
      n.p_exc = 1'b0;
    end
  end

  // State register, lines idle high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.a <= 1'b1;
      s.b <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign trk_a     = s.a;
  assign trk_b     = s.b;
  assign trk_phase = s.ph;

  property p_phase_toggle;
    @(posedge core_clk) disable iff (!rstn)
    (trk_phase == 1'b0) |=> (trk_phase == 1'b1) ##1 (trk_phase == 1'b0);
  endproperty
  a_phase_toggle: assert property (p_phase_toggle) else $error("phase not alternating");

  property p_inval_code;
    @(posedge core_clk) disable iff (!rstn)
    (trk_phase && (lk.invalid || s.p_inv)) |=> (!trk_a && !trk_b);
  endproperty
  a_inval_code: assert property (p_inval_code) else $error("invalid code not shown");
endmodule

// ==== src/cpu_seq_core.sv ====
// Instruction prefetch pipeline, sequencer and exception vectoring
`timescale 1ns/1ps
module cpu_seq_core #(
  parameter int unsigned OPS_W = 4
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Memory bus
  output logic                       bus_req,
  output logic                       bus_wr,
  output logic                       bus_prog_space,
  output logic [19:0]                bus_addr,
  output logic [15:0]                bus_wdata,
  input  wire logic                  bus_ack,
  input  wire logic [15:0]           bus_rdata,
  // Execution unit
  input  wire logic                  exec_done,
  input  wire logic [OPS_W-1:0]      exec_int_ops,
  input  wire logic                  exec_flow,
  input  wire logic                  exec_flow_temp,
  input  wire logic [19:0]           exec_flow_target,
  output logic                       exec_start,
  output logic [15:0]                stage_a_word,
  output logic [15:0]                stage_b_opcode,
  output logic [7:0]                 stage_b_operand8,
  output logic [15:0]                stage_c_opcode,
  output logic [19:0]                return_addr,
  // Exception request
  input  wire logic                  exc_req,
  input  wire logic                  exc_ext,
  input  wire logic                  exc_auto,
  input  wire logic [2:0]            exc_level,
  input  wire logic [7:0]            exc_vec,
  input  wire cpu_seq_pkg::exc_kind_t exc_kind,
  output logic                       exc_ack,
  output logic                       vec_user,
  // Pipeline tracking
  output logic                       pipe_track_out_a,
  output logic                       pipe_track_out_b,
  output logic                       track_phase
);
  if (OPS_W < 1 || OPS_W > 8) begin : g_bad_ops
    $error("OPS_W must be 1 to 8");
  end

  typedef enum logic [7:0] {
    S_RSTV   = 8'h01,
    S_FILL   = 8'h02,
    S_EXEC   = 8'h04,
    S_INTOP  = 8'h08,
    S_RETIRE = 8'h10,
    S_PUSHPC = 8'h20,
    S_PUSHCC = 8'h40,
    S_VEC    = 8'h80
  } state_t;

  typedef struct packed {
    state_t                 st;
    logic                   step;
    logic [1:0]             rwi;
    logic                   breq;
    logic                   bwr;
    logic                   bprog;
    logic                   bfetch;
    logic                   bcnt;
    logic [19:0]            baddr;
    logic [15:0]            bwdata;
    logic [15:0]            pc;
    logic [15:0]            ccode;
    logic [15:0]            sp;
    logic [15:0]            dpix;
    logic [3:0]             sbank;
    logic [3:0]             zbank;
    logic [15:0]            a;
    logic [15:0]            b;
    logic [15:0]            c;
    logic [15:0]            pf;
    logic [19:0]            a_addr;
    logic [19:0]            b_addr;
    logic [19:0]            pf_addr;
    logic                   a_v;
    logic                   b_v;
    logic                   pf_v;
    logic                   flow;
    logic                   ftmp;
    logic [19:0]            ftgt;
    logic [19:0]            ret;
    logic [OPS_W:0]         cnt;
    logic                   xext;
    logic                   xauto;
    logic [2:0]             xlvl;
    logic [7:0]             xvec;
    cpu_seq_pkg::exc_kind_t xkind;
    logic                   start;
    logic                   ack;
    logic                   fetch;
    logic                   adv;
    logic                   excp;
    logic                   inval;
  } seq_t;

  seq_t s, n;
  logic done;
  core_link_if lk ();

  // Open a bus cycle with the given address, direction and space
  function automatic seq_t go(seq_t x, logic [19:0] ad, logic wr, logic prog, logic fch,
                              logic [15:0] wd);
    seq_t y;
    y = x;
    y.breq   = 1'b1;
    y.bcnt   = 1'b0;
    y.baddr  = ad;
    y.bwr    = wr;
    y.bprog  = prog;
    y.bfetch = fch;
    y.bwdata = wd;
    return y;
  endfunction

  // Bus cycle ends on ack, never before its second clock
  assign done = s.breq && s.bcnt && bus_ack;

  // Sequencer next state
  always_comb begin
    n = s;
    n.start = 1'b0;
    n.ack   = 1'b0;
    n.fetch = 1'b0;
    n.adv   = 1'b0;
    n.excp  = 1'b0;
    n.inval = 1'b0;
    if (s.breq) begin
      n.bcnt = 1'b1;
    end
    if (done) begin
      n.breq = 1'b0;
      n.bcnt = 1'b0;
      n.bwr  = 1'b0;
    end
    // Prefetch words park ahead of stage A
    if (done && s.bfetch && s.st != S_FILL) begin
      n.pf   = bus_rdata;
      n.pf_v = 1'b1;
    end
    unique case (s.st)
      // Four program-space reset words load banks, counter, stack, index
      S_RSTV: begin
        if (!s.breq && !s.step) begin
          n = go(n, 20'({s.rwi, 1'b0}), 1'b0, 1'b1, 1'b0, 16'h0000);
          n.step = 1'b1;
        end else if (done) begin
          n.step = 1'b0;
          n.rwi  = 2'(s.rwi + 2'h1);
          unique case (s.rwi)
            2'h0: begin
              n.zbank = bus_rdata[cpu_seq_pkg::ZBANK_LSB +: 4];
              n.sbank = bus_rdata[cpu_seq_pkg::SBANK_LSB +: 4];
              n.ccode[cpu_seq_pkg::PBANK_LSB +: 4] = bus_rdata[cpu_seq_pkg::PBANK_LSB +: 4];
            end
            2'h1: n.pc = bus_rdata;
            2'h2: n.sp = bus_rdata;
            default: n.dpix = bus_rdata;
          endcase
          if (s.rwi == cpu_seq_pkg::RST_WORDS_LAST) begin
            n.st = S_FILL;
          end
        end
      end
      // Refill A then B from the current stream
      S_FILL: begin
        if (done && s.bfetch) begin
          n.a      = bus_rdata;
          n.a_addr = s.baddr;
          n.a_v    = 1'b1;
          if (s.a_v) begin
            n.b      = s.a;
            n.b_addr = s.a_addr;
            n.b_v    = 1'b1;
            n.adv    = 1'b1;
          end
        end else if (!s.breq) begin
          n = go(n, {s.ccode[3:0], s.pc}, 1'b0, 1'b1, 1'b1, 16'h0000);
          n.pc    = 16'(s.pc + cpu_seq_pkg::WORD_STEP);
          n.fetch = 1'b1;
          if (s.a_v && s.b_v) begin
            n.pf_addr = {s.ccode[3:0], s.pc};
            n.pf_v    = 1'b0;
            n.start   = 1'b1;
            n.st      = S_EXEC;
          end
        end
      end
      // One instruction in stage B at a time
      S_EXEC: begin
        if (exec_done) begin
          n.cnt  = {exec_int_ops, 1'b0};
          n.flow = exec_flow;
          n.ftmp = exec_flow_temp;
          n.ftgt = exec_flow_target;
          n.st   = (exec_int_ops == '0) ? S_RETIRE : S_INTOP;
        end
      end
      // Two clocks per internal operation
      S_INTOP: begin
        n.cnt = (OPS_W + 1)'(s.cnt - 1'b1);
        if (s.cnt <= 1) begin
          n.st = S_RETIRE;
        end
      end
      // Retire to C, then branch, take an exception, or advance
      S_RETIRE: begin
        if (!s.breq) begin
          n.c = s.b;
          if (s.flow) begin
            n.pc         = s.ftgt[15:0];
            n.ccode[3:0] = s.ftgt[19:16];
            n.ret        = s.ftmp ? s.a_addr : s.ret;
            n.a_v        = 1'b0;
            n.b_v        = 1'b0;
            n.pf_v       = 1'b0;
            n.inval      = 1'b1;
            n.st         = S_FILL;
          end else if (exc_req) begin
            n.ret   = 20'(s.a_addr + cpu_seq_pkg::RET_OFS);
            n.xext  = exc_ext;
            n.xauto = exc_auto;
            n.xlvl  = exc_level;
            n.xvec  = exc_vec;
            n.xkind = exc_kind;
            n.ack   = 1'b1;
            n.excp  = 1'b1;
            n.inval = 1'b1;
            n.a_v   = 1'b0;
            n.b_v   = 1'b0;
            n.pf_v  = 1'b0;
            n.step  = 1'b0;
            n.st    = S_PUSHPC;
          end else begin
            n.b       = s.a;
            n.b_addr  = s.a_addr;
            n.a       = s.pf;
            n.a_addr  = s.pf_addr;
            n.adv     = 1'b1;
            n         = go(n, {s.ccode[3:0], s.pc}, 1'b0, 1'b1, 1'b1, 16'h0000);
            n.pf_addr = {s.ccode[3:0], s.pc};
            n.pf_v    = 1'b0;
            n.pc      = 16'(s.pc + cpu_seq_pkg::WORD_STEP);
            n.fetch   = 1'b1;
            n.start   = 1'b1;
            n.st      = S_EXEC;
          end
        end
      end
      // Push low counter word at the stack
      S_PUSHPC: begin
        if (!s.breq && !s.step) begin
          n.sp   = 16'(s.sp - cpu_seq_pkg::WORD_STEP);
          n      = go(n, {s.sbank, n.sp}, 1'b1, 1'b0, 1'b0, s.ret[15:0]);
          n.step = 1'b1;
        end else if (done) begin
          n.step = 1'b0;
          n.st   = S_PUSHCC;
        end
      end
      // Push condition codes carrying the return bank, then clear it
      S_PUSHCC: begin
        if (!s.breq && !s.step) begin
          n.sp       = 16'(s.sp - cpu_seq_pkg::WORD_STEP);
          n            = go(n, {s.sbank, n.sp}, 1'b1, 1'b0, 1'b0, {s.ccode[15:4], s.ret[19:16]});
          n.ccode[3:0] = 4'h0;
          n.step     = 1'b1;
        end else if (done) begin
          n.step = 1'b0;
          n.st   = S_VEC;
        end
      end
      // One data-space vector word from bank 0
      S_VEC: begin
        if (!s.breq && !s.step) begin
          n      = go(n, 20'(lk.vaddr), 1'b0, 1'b0, 1'b0, 16'h0000);
          n.step = 1'b1;
        end else if (done) begin
          n.pc   = bus_rdata;
          n.step = 1'b0;
          n.st   = S_FILL;
        end
      end
      default: n.st = S_RSTV;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s    <= '0;
      s.st <= S_RSTV;
    end else begin
      s <= n;
    end
  end

  assign lk.fetch   = s.fetch;
  assign lk.start   = s.start;
  assign lk.advance = s.adv;
  assign lk.excp    = s.excp;
  assign lk.invalid = s.inval;
  assign lk.xext    = s.xext;
  assign lk.xauto   = s.xauto;
  assign lk.xlvl    = s.xlvl;
  assign lk.xvec    = s.xvec;
  assign lk.xkind   = s.xkind;

  vec_map u_map (
    .core_clk (core_clk),
    .rstn     (rstn),
    .lk       (lk.map)
  );

  track_enc u_trk (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .lk        (lk.enc),
    .trk_a     (pipe_track_out_a),
    .trk_b     (pipe_track_out_b),
    .trk_phase (track_phase)
  );

  // Registered outputs
  assign bus_req          = s.breq;
  assign bus_wr           = s.bwr;
  assign bus_prog_space   = s.bprog;
  assign bus_addr         = s.baddr;
  assign bus_wdata        = s.bwdata;
  assign exec_start       = s.start;
  assign stage_a_word     = s.a;
  assign stage_b_opcode   = s.b;
  assign stage_b_operand8 = s.b[7:0];
  assign stage_c_opcode   = s.c;
  assign return_addr      = s.ret;
  assign exc_ack          = s.ack;
  assign vec_user         = lk.vuser;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_bus_min;
    $rose(bus_req) |-> bus_req [*2];
  endproperty
  a_bus_min: assert property (p_bus_min) else $error("bus cycle under two clocks");

  property p_rst_words;
    (s.st == S_RSTV && bus_req) |-> (bus_prog_space && !bus_wr && bus_addr < 20'h00008);
  endproperty
  a_rst_words: assert property (p_rst_words) else $error("reset word fetch wrong");

  property p_pc_ahead;
    exec_start |-> (s.pc == 16'(s.b_addr[15:0] + cpu_seq_pkg::PF_AHEAD));
  endproperty
  a_pc_ahead: assert property (p_pc_ahead) else $error("counter not six ahead");

  property p_intop_one;
    (s.st == S_EXEC && exec_done && exec_int_ops == 1) |=> (s.st == S_INTOP) [*2] ##1
      (s.st == S_RETIRE);
  endproperty
  a_intop_one: assert property (p_intop_one) else $error("internal op not two clocks");

  property p_advance;
    (s.st == S_RETIRE && !bus_req && !s.flow && !exc_req) |=>
      (stage_b_opcode == $past(s.a) && stage_c_opcode == $past(s.b));
  endproperty
  a_advance: assert property (p_advance) else $error("pipeline advance wrong");

  property p_flow;
    (s.st == S_RETIRE && !bus_req && s.flow) |=>
      (s.pc == $past(s.ftgt[15:0]) && !s.a_v && !s.b_v && s.st == S_FILL);
  endproperty
  a_flow: assert property (p_flow) else $error("flow change not flushed");

  property p_stack_write;
    bus_wr |-> (bus_addr == {s.sbank, s.sp} && !bus_prog_space);
  endproperty
  a_stack_write: assert property (p_stack_write) else $error("stack write address wrong");

  property p_vec_read;
    (s.st == S_VEC && bus_req) |-> (!bus_prog_space && bus_addr[19:9] == 11'h000 &&
      s.ccode[3:0] == 4'h0);
  endproperty
  a_vec_read: assert property (p_vec_read) else $error("vector read wrong");
endmodule

// ==== testbench/mem_model.sv ====
// Memory partner answering core bus cycles after a chosen wait
`timescale 1ns/1ps
module mem_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Core bus
  input  wire logic        bus_req,
  input  wire logic [19:0] bus_addr,
  input  wire logic        slow,
  output logic             bus_ack,
  output logic [15:0]      bus_rdata
);
  logic [2:0]  age_q;
  logic [15:0] val;
  // Age of the open request
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) age_q <= 3'h0;
    else if (bus_req && !bus_ack) age_q <= age_q + 3'h1;
    else age_q <= 3'h0;
  end
  // Reset words, vectors in bank 0, code word equals its address
  always_comb begin
    case (bus_addr)
      20'h00000: val = 16'h0321;
      20'h00002: val = 16'h0100;
      20'h00004: val = 16'h0400;
      20'h00006: val = 16'h0055;
      default:   val = (bus_addr < 20'h00200) ? 16'h0300 + bus_addr[15:0] : bus_addr[15:0];
    endcase
  end
  // Never in the first cycle, later when slow
  assign bus_ack   = bus_req && (age_q >= (slow ? 3'h3 : 3'h1));
  assign bus_rdata = bus_ack ? val : ~val;
endmodule

// ==== testbench/tb_cpu_pipeline_exception_vectoring.sv ====
// Self-checking bench for the sequencer and exception vectoring
`timescale 1ns/1ps
module tb_cpu_pipeline_exception_vectoring;
  logic                   core_clk, rstn, bus_req, bus_wr, bus_prog, bus_ack, slow;
  logic                   exec_done, exec_flow, exc_req, exc_ext, exc_auto, exc_ack;
  logic                   vec_user, exec_start, trk_a, trk_b, trk_ph;
  logic [19:0]            bus_addr, flow_tgt, ret_addr, sp_now;
  logic [15:0]            bus_wdata, bus_rdata, st_a, st_b, st_c, cur_b;
  logic [7:0]             op8, exc_vec;
  logic [3:0]             ops, ret_bank;
  logic [2:0]             exc_level;
  cpu_seq_pkg::exc_kind_t exc_kind;
  logic [37:0]            log_q[$];
  int                     bad_count, total_checks, cyc;
  cpu_seq_core dut_u (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .bus_wr(bus_wr),
    .bus_prog_space(bus_prog), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .exec_done(exec_done), .exec_int_ops(ops), .exec_flow(exec_flow),
    .exec_flow_temp(exec_flow), .exec_flow_target(flow_tgt), .exec_start(exec_start),
    .stage_a_word(st_a), .stage_b_opcode(st_b), .stage_b_operand8(op8), .stage_c_opcode(st_c),
    .return_addr(ret_addr), .exc_req(exc_req), .exc_ext(exc_ext), .exc_auto(exc_auto),
    .exc_level(exc_level), .exc_vec(exc_vec), .exc_kind(exc_kind), .exc_ack(exc_ack),
    .vec_user(vec_user), .pipe_track_out_a(trk_a), .pipe_track_out_b(trk_b),
    .track_phase(trk_ph));
  mem_model mem_u (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .bus_addr(bus_addr),
    .slow(slow), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Log of taken bus cycles and the cycle ceiling
  always @(negedge core_clk) begin
    cyc++;
    if (bus_req === 1'b1 && bus_ack === 1'b1) log_q.push_back({bus_wr, bus_prog, bus_addr, bus_wdata});
    if (cyc > 40000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic check(input string what, input logic [37:0] seen, input logic [37:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait for the next start; returns cycles waited
  task automatic wait_start(output int n);
    n = 0;
    @(negedge core_clk);
    while (exec_start !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    check("start", exec_start, 1'b1);
  endtask
  // One finish pulse from the execution unit
  task automatic done(input logic [3:0] o, input logic fl, input logic [19:0] tgt);
    @(posedge core_clk);
    exec_done <= 1'b1;
    ops <= o;
    exec_flow <= fl;
    flow_tgt <= tgt;
    @(posedge core_clk);
    exec_done <= 1'b0;
    exec_flow <= 1'b0;
  endtask
  task automatic t_reset();
    int n;
    wait_start(n);
    for (int i = 0; i < 4; i++) check("reset word", log_q[i][37:16], {2'h1, 20'(i * 2)});
    for (int i = 4; i < 6; i++) check("fill", log_q[i][37:16], {2'h1, 20'h10100 + 20'((i - 4) * 2)});
    check("stage b", st_b, 16'h0100);
    check("stage a", st_a, 16'h0102);
  endtask
  task automatic t_advance();
    int n;
    slow = 1'b1;
    done(4'h2, 1'b0, 20'h0);
    wait_start(n);
    check("op time", n >= 4, 1'b1);
    check("stage c", st_c, 16'h0100);
    check("stage b", st_b, 16'h0102);
    check("stage a", st_a, 16'h0104);
    check("operand8", op8, 8'h02);
    slow = 1'b0;
  endtask
  task automatic t_flow();
    int n;
    done(4'h0, 1'b1, 20'h10200);
    wait_start(n);
    check("new b", st_b, 16'h0200);
    check("new a", st_a, 16'h0202);
    check("flow c", st_c, 16'h0102);
    check("flow return", ret_addr, 20'h10104);
  endtask
  // One exception; k gives kind and level, va the expected vector address
  task automatic t_exc(input logic [2:0] k, input logic ex, input logic au, input logic [7:0] v,
                       input logic [19:0] va);
    int n;
    int w;
    log_q.delete();
    @(posedge core_clk);
    exc_req <= 1'b1;
    exc_ext <= ex;
    exc_auto <= au;
    exc_vec <= v;
    exc_kind <= cpu_seq_pkg::exc_kind_t'(k);
    exc_level <= k;
    done(4'h0, 1'b0, 20'h0);
    n = 0;
    while (exc_ack !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    check("ack", exc_ack, 1'b1);
    @(posedge core_clk);
    exc_req <= 1'b0;
    wait_start(n);
    w = 0;
    foreach (log_q[i]) begin
      if (log_q[i][37] === 1'b1) begin
        check("push", log_q[i][35:16], sp_now - 20'(2 + 2 * w));
        if (w == 0) check("push pc", log_q[i][15:0], cur_b + 16'h0008);
        if (w == 1) check("cc bank", log_q[i][3:0], ret_bank);
        w++;
      end else if (log_q[i][36] === 1'b0) check("vector", log_q[i][35:16], va);
    end
    check("pushes", w, 2);
    check("handler", st_b, 16'h0300 + va[15:0]);
    check("user", vec_user, va >= 20'h00070);
    check("return", ret_addr, {ret_bank, cur_b + 16'h0008});
    sp_now = sp_now - 20'h4;
    ret_bank = 4'h0;
    cur_b = 16'h0300 + va[15:0];
  endtask
  // Main sequence
  initial begin
    {rstn, slow, exec_done, exec_flow, exc_req, exc_ext, exc_auto} = 7'h0;
    {ops, flow_tgt, exc_vec, exc_level} = '0;
    exc_kind = cpu_seq_pkg::EXK_SWI;
    sp_now = 20'h20400;
    ret_bank = 4'h1;
    cur_b = 16'h0200;
    repeat (4) @(posedge core_clk);
    check("idle track", {trk_a, trk_b, trk_ph, bus_req}, 4'hc);
    rstn <= 1'b1;
    t_reset();
    t_advance();
    t_flow();
    t_exc(3'h2, 1'b0, 1'b0, 8'h00, 20'h0000c);
    t_exc(3'h0, 1'b1, 1'b0, 8'h40, 20'h00080);
    t_exc(3'h0, 1'b1, 1'b0, 8'h37, 20'h0006e);
    t_exc(3'h3, 1'b1, 1'b1, 8'h00, 20'h00026);
    for (int k = 0; k < 7; k++) begin
      t_exc(3'(k), 1'b0, 1'b0, 8'h00,
            {11'h0, k == 6 ? 8'h18 : k == 5 ? 8'h0f : 8'(k + 4), 1'b0});
    end
    end_of_test();
  end
endmodule
